// [rtl/ras_cfg.svh]
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH
// ---------------------------------------------------------------
// Frame bytes and command codes
// ---------------------------------------------------------------
`define RAS_START 8'h02
`define RAS_CMD_SET 8'h09
`define RAS_CMD_GET 8'h0a
`define RAS_CMD_RT_NET 8'h2a
`define RAS_CMD_RT_ADDR 8'h2b
`define RAS_CNF_BIT 8'h40
`define RAS_ST_OK 8'h00
`define RAS_ST_FAIL 8'h01
// ---------------------------------------------------------------
// Settings indexes and reset values
// ---------------------------------------------------------------
`define RAS_IDX_DEST_NET 8'h07
`define RAS_IDX_DEST_ADDR 8'h08
`define RAS_IDX_OWN_NET 8'h0a
`define RAS_IDX_OWN_ADDR 8'h0b
`define RAS_RST_DEST_NET 8'hff
`define RAS_RST_DEST_ADDR 16'hffff
`define RAS_RST_OWN_NET 8'h00
`define RAS_RST_OWN_ADDR 16'h0000
`define RAS_BCAST8 8'hff
`define RAS_BCAST16 16'hffff
`define RAS_LEN_ONE 8'h02
`define RAS_LEN_TWO 8'h03
// ---------------------------------------------------------------
// Host APB register offsets and fields
// ---------------------------------------------------------------
`define RAS_OFS_REQ 8'h00
`define RAS_OFS_DATA 8'h04
`define RAS_OFS_GO 8'h08
`define RAS_OFS_STAT 8'h0c
`define RAS_OFS_RESP 8'h10
`define RAS_STAT_BUSY 0
`define RAS_STAT_DONE 1
`define RAS_STAT_CSERR 2
`define RAS_STAT_REFUSED 3
`endif

// [rtl/ras_pkg.sv]
package ras_pkg;
  // Device parser and sender states
  typedef enum logic [2:0] {DS_IDLE, DS_CMD, DS_LEN, DS_DATA, DS_CS, DS_EXEC, DS_SEND}
    ras_dev_state_type;
  // Host sequencer states
  typedef enum logic [2:0] {HS_IDLE, HS_SEND, HS_WAIT, HS_RCMD, HS_RLEN, HS_RDATA, HS_RCS}
    ras_host_state_type;
  // Byte of a frame
  typedef logic [7:0] ras_byte_type;
endpackage : ras_pkg

// [rtl/ras_link_if.sv]
`timescale 1ns/10ps
interface ras_link_if;
  logic h2d_valid; // Request byte strobe
  logic [7:0] h2d_data; // Request byte
  logic d2h_valid; // Answer byte strobe
  logic [7:0] d2h_data; // Answer byte
  modport dev (input h2d_valid, input h2d_data, output d2h_valid, output d2h_data);
  modport host (output h2d_valid, output h2d_data, input d2h_valid, input d2h_data);
endinterface : ras_link_if

// [rtl/ras_device.sv]
`timescale 1ns/10ps
`include "ras_cfg.svh"
module ras_device (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  ras_link_if.dev link,
  input wire logic [1:0] addr_mode_i,
  output logic [7:0] dest_network_o,
  output logic [15:0] dest_address_o,
  output logic [7:0] own_network_o,
  output logic [15:0] own_address_o,
  output logic dest_broadcast_o
);
  import ras_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ras_dev_state_type state_reg; // Parser and sender state
  ras_byte_type cmd_reg; // Command of the frame
  ras_byte_type len_reg; // Length field
  ras_byte_type buf_reg [0:2]; // Bytes between length and checksum
  logic [1:0] cnt_reg; // Bytes taken so far
  ras_byte_type cs_reg; // Running XOR of the request
  ras_byte_type tx_buf_reg [0:5]; // Answer bytes before checksum
  logic [2:0] tx_n_reg; // Answer byte count before checksum
  logic [2:0] tx_idx_reg; // Next answer byte
  ras_byte_type tx_cs_reg; // Running XOR of the answer
  logic d2h_valid_reg; // Answer strobe
  ras_byte_type d2h_data_reg; // Answer byte
  ras_byte_type def_net_reg; // Stored destination network
  logic [15:0] def_addr_reg; // Stored destination address
  ras_byte_type own_net_reg; // Own network id
  logic [15:0] own_addr_reg; // Own device address
  ras_byte_type rt_net_reg; // Runtime destination network
  logic [15:0] rt_addr_reg; // Runtime destination address
  logic [15:0] tx_addr_reg; // Destination address as sent
  logic bcast_reg; // Broadcast flag

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire in_v = link.h2d_valid; // Same-clock logic, no sync
  wire [7:0] in_b = link.h2d_data;
  wire is_set = (cmd_reg == `RAS_CMD_SET);
  wire is_get = (cmd_reg == `RAS_CMD_GET);
  wire is_rtn = (cmd_reg == `RAS_CMD_RT_NET);
  wire is_rta = (cmd_reg == `RAS_CMD_RT_ADDR);
  wire known = is_set | is_get | is_rtn | is_rta;
  wire [7:0] idx = buf_reg[0];
  wire len_one = (len_reg == `RAS_LEN_ONE);
  wire len_two = (len_reg == `RAS_LEN_TWO);
  wire cs_ok = (in_b == cs_reg);
  // Set value: high byte forced when only one byte given
  wire [15:0] set_v16 = len_two ? {buf_reg[2], buf_reg[1]} : {8'hff, buf_reg[1]};
  wire [15:0] rt_v16 = (len_reg == 8'h02) ? {buf_reg[1], buf_reg[0]} : {8'hff, buf_reg[0]};
  // Per-setting write acceptance
  wire w_dnet = is_set && idx == `RAS_IDX_DEST_NET && len_one;
  wire w_daddr = is_set && idx == `RAS_IDX_DEST_ADDR && (len_one | len_two);
  wire w_onet = is_set && idx == `RAS_IDX_OWN_NET && len_one
    && buf_reg[1] != `RAS_BCAST8;
  wire w_oaddr = is_set && idx == `RAS_IDX_OWN_ADDR && (len_one | len_two)
    && set_v16 != `RAS_BCAST16;
  wire w_rtn = is_rtn && len_reg == 8'h01;
  wire w_rta = is_rta && (len_reg == 8'h01 || len_reg == 8'h02);
  wire set_ok = w_dnet | w_daddr | w_onet | w_oaddr | w_rtn | w_rta;
  // Read selection
  wire g_len = is_get && len_reg == 8'h01;
  wire g_dnet = g_len && idx == `RAS_IDX_DEST_NET;
  wire g_daddr = g_len && idx == `RAS_IDX_DEST_ADDR;
  wire g_onet = g_len && idx == `RAS_IDX_OWN_NET;
  wire g_oaddr = g_len && idx == `RAS_IDX_OWN_ADDR;
  wire get_ok = g_dnet | g_daddr | g_onet | g_oaddr;
  wire get_two = g_daddr | g_oaddr;
  wire [15:0] get_val = g_dnet ? {8'h00, def_net_reg} :
                        g_daddr ? def_addr_reg :
                        g_onet ? {8'h00, own_net_reg} : own_addr_reg;
  // Answer fields
  wire [7:0] r_status = (is_get ? get_ok : set_ok) ? `RAS_ST_OK : `RAS_ST_FAIL;
  wire [7:0] r_len = !get_ok ? 8'h01 : (get_two ? 8'h03 : 8'h02);
  wire [2:0] r_n = get_ok ? (get_two ? 3'd6 : 3'd5) : 3'd4;
  wire tx_last = (tx_idx_reg == tx_n_reg);
  wire [7:0] tx_byte = tx_last ? tx_cs_reg : tx_buf_reg[tx_idx_reg];
  // Broadcast per address mode
  wire lo_bc = (rt_addr_reg[7:0] == `RAS_BCAST8);
  wire net_bc = (rt_net_reg == `RAS_BCAST8);
  wire bc_next = (addr_mode_i == 2'd0) ? 1'b1 :
                 (addr_mode_i == 2'd1) ? lo_bc :
                 (addr_mode_i == 2'd2) ? (lo_bc | net_bc) :
                 (net_bc && rt_addr_reg == `RAS_BCAST16);
  wire [15:0] addr_next = (addr_mode_i == 2'd3) ? rt_addr_reg
                                                : {8'h00, rt_addr_reg[7:0]};

  // ---------------------------------------------------------------
  // Frame parser and answer sender
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= DS_IDLE;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      cnt_reg <= 2'd0;
      cs_reg <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        buf_reg[i] <= 8'h00;
      end
      for (int i = 0; i < 6; i++) begin
        tx_buf_reg[i] <= 8'h00;
      end
      tx_n_reg <= 3'd0;
      tx_idx_reg <= 3'd0;
      tx_cs_reg <= 8'h00;
      d2h_valid_reg <= 1'b0;
      d2h_data_reg <= 8'h00;
    end else begin
      d2h_valid_reg <= 1'b0;
      unique case (state_reg)
        // Hunt for the start byte
        DS_IDLE: begin
          if (in_v && in_b == `RAS_START) begin
            cs_reg <= in_b;
            state_reg <= DS_CMD;
          end
        end
        // Command byte
        DS_CMD: begin
          if (in_v) begin
            cmd_reg <= in_b;
            cs_reg <= cs_reg ^ in_b;
            state_reg <= DS_LEN;
          end
        end
        // Length byte; oversize frames dropped
        DS_LEN: begin
          if (in_v) begin
            len_reg <= in_b;
            cs_reg <= cs_reg ^ in_b;
            cnt_reg <= 2'd0;
            if (in_b == 8'h00 || in_b > 8'h03) begin
              state_reg <= DS_IDLE;
            end else begin
              state_reg <= DS_DATA;
            end
          end
        end
        // Index and parameter bytes
        DS_DATA: begin
          if (in_v) begin
            buf_reg[cnt_reg] <= in_b;
            cs_reg <= cs_reg ^ in_b;
            cnt_reg <= cnt_reg + 2'd1;
            if ({6'd0, cnt_reg} + 8'd1 == len_reg) begin
              state_reg <= DS_CS;
            end
          end
        end
        // Checksum; mismatch or unknown command drops the frame
        DS_CS: begin
          if (in_v) begin
            state_reg <= (cs_ok && known) ? DS_EXEC : DS_IDLE;
          end
        end
        // Build the answer
        DS_EXEC: begin
          tx_buf_reg[0] <= `RAS_START;
          tx_buf_reg[1] <= cmd_reg | `RAS_CNF_BIT;
          tx_buf_reg[2] <= r_len;
          tx_buf_reg[3] <= r_status;
          tx_buf_reg[4] <= get_val[7:0];
          tx_buf_reg[5] <= get_val[15:8];
          tx_n_reg <= r_n;
          tx_idx_reg <= 3'd0;
          tx_cs_reg <= 8'h00;
          state_reg <= DS_SEND;
        end
        // One answer byte per cycle, checksum last
        DS_SEND: begin
          d2h_valid_reg <= 1'b1;
          d2h_data_reg <= tx_byte;
          tx_cs_reg <= tx_cs_reg ^ tx_byte;
          tx_idx_reg <= tx_idx_reg + 3'd1;
          if (tx_last) begin
            state_reg <= DS_IDLE;
          end
        end
        // Unused state code falls back to hunting
        default: begin
          state_reg <= DS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Settings storage, written only from a good frame
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      def_net_reg <= `RAS_RST_DEST_NET;
      def_addr_reg <= `RAS_RST_DEST_ADDR;
      own_net_reg <= `RAS_RST_OWN_NET;
      own_addr_reg <= `RAS_RST_OWN_ADDR;
      rt_net_reg <= `RAS_RST_DEST_NET;
      rt_addr_reg <= `RAS_RST_DEST_ADDR;
    end else if (state_reg == DS_EXEC) begin
      // Stored default write also reloads the runtime copy
      if (w_dnet) begin
        def_net_reg <= buf_reg[1];
        rt_net_reg <= buf_reg[1];
      end
      if (w_daddr) begin
        def_addr_reg <= set_v16;
        rt_addr_reg <= set_v16;
      end
      if (w_onet) begin
        own_net_reg <= buf_reg[1];
      end
      if (w_oaddr) begin
        own_addr_reg <= set_v16;
      end
      // Runtime-only changes leave defaults alone
      if (w_rtn) begin
        rt_net_reg <= buf_reg[0];
      end
      if (w_rta) begin
        rt_addr_reg <= rt_v16;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered user outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_addr_reg <= 16'h0000;
      bcast_reg <= 1'b0;
    end else begin
      tx_addr_reg <= addr_next;
      bcast_reg <= bc_next;
    end
  end

  assign link.d2h_valid = d2h_valid_reg;
  assign link.d2h_data = d2h_data_reg;
  assign dest_network_o = rt_net_reg;
  assign dest_address_o = tx_addr_reg;
  assign own_network_o = own_net_reg;
  assign own_address_o = own_addr_reg;
  assign dest_broadcast_o = bcast_reg;
endmodule : ras_device

// [rtl/ras_host.sv]
`timescale 1ns/10ps
`include "ras_cfg.svh"
module ras_host (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  ras_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ras_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ras_host_state_type st_reg; // Sequencer state
  logic [15:0] req_reg; // Command [7:0], length [15:8]
  logic [23:0] data_reg; // Bytes after the length
  logic [2:0] idx_reg; // Frame byte counter
  ras_byte_type cs_reg; // Running XOR
  logic h2d_valid_reg; // Request strobe
  ras_byte_type h2d_data_reg; // Request byte
  logic busy_reg, done_reg, cserr_reg, refused_reg; // Status bits
  ras_byte_type rx_cmd_reg, rx_len_reg, rx_stat_reg; // Answer header
  logic [15:0] rx_par_reg; // Answer parameters, LSB first
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire setup = psel && !penable;
  wire wr_ev = psel && penable && pready_reg && pwrite;
  wire hit_req = (paddr == `RAS_OFS_REQ);
  wire hit_data = (paddr == `RAS_OFS_DATA);
  wire hit_go = (paddr == `RAS_OFS_GO);
  wire hit_stat = (paddr == `RAS_OFS_STAT);
  wire hit_resp = (paddr == `RAS_OFS_RESP);
  wire mapped = hit_req | hit_data | hit_go | hit_stat | hit_resp;
  wire [31:0] rd_val = hit_req ? {16'h0000, req_reg} :
                       hit_data ? {8'h00, data_reg} :
                       hit_stat ? {8'h00, rx_stat_reg, rx_cmd_reg, 4'h0, refused_reg,
                                   cserr_reg, done_reg, busy_reg} :
                       hit_resp ? {16'h0000, rx_par_reg} : 32'h0000_0000;
  // Own network/address broadcast values never leave the host
  wire set_cmd = (req_reg[7:0] == `RAS_CMD_SET);
  wire bad_onet = data_reg[7:0] == `RAS_IDX_OWN_NET && data_reg[15:8] == `RAS_BCAST8;
  wire bad_oaddr = data_reg[7:0] == `RAS_IDX_OWN_ADDR && data_reg[15:8] == `RAS_BCAST8
    && (req_reg[15:8] == `RAS_LEN_ONE || data_reg[23:16] == `RAS_BCAST8);
  wire refuse = set_cmd && (bad_onet || bad_oaddr);
  wire len_bad = req_reg[15:8] == 8'h00 || req_reg[15:8] > 8'h03;
  // Outgoing byte: start, command, length, data, checksum
  wire [2:0] last_idx = 3'(req_reg[10:8]) + 3'd3;
  wire [7:0] data_b = (idx_reg == 3'd3) ? data_reg[7:0] :
                      (idx_reg == 3'd4) ? data_reg[15:8] : data_reg[23:16];
  wire [7:0] out_b = (idx_reg == 3'd0) ? `RAS_START :
                     (idx_reg == 3'd1) ? req_reg[7:0] :
                     (idx_reg == 3'd2) ? req_reg[15:8] :
                     (idx_reg == last_idx) ? cs_reg : data_b;
  wire in_v = link.d2h_valid;
  wire [7:0] in_b = link.d2h_data;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      req_reg <= 16'h0000;
      data_reg <= 24'h000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= setup ? rd_val : 32'h0000_0000;
      if (wr_ev && hit_req && !busy_reg) begin
        req_reg <= pwdata[15:0];
      end
      if (wr_ev && hit_data && !busy_reg) begin
        data_reg <= pwdata[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame sender and answer collector
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= HS_IDLE;
      idx_reg <= 3'd0;
      cs_reg <= 8'h00;
      h2d_valid_reg <= 1'b0;
      h2d_data_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cserr_reg <= 1'b0;
      refused_reg <= 1'b0;
      rx_cmd_reg <= 8'h00;
      rx_len_reg <= 8'h00;
      rx_stat_reg <= 8'h00;
      rx_par_reg <= 16'h0000;
    end else begin
      h2d_valid_reg <= 1'b0;
      unique case (st_reg)
        // Wait for a go write
        HS_IDLE: begin
          if (wr_ev && hit_go) begin
            done_reg <= 1'b0;
            cserr_reg <= 1'b0;
            refused_reg <= refuse | len_bad;
            if (!(refuse | len_bad)) begin
              busy_reg <= 1'b1;
              idx_reg <= 3'd0;
              cs_reg <= 8'h00;
              st_reg <= HS_SEND;
            end
          end
        end
        // One byte per cycle
        HS_SEND: begin
          h2d_valid_reg <= 1'b1;
          h2d_data_reg <= out_b;
          cs_reg <= cs_reg ^ out_b;
          idx_reg <= idx_reg + 3'd1;
          if (idx_reg == last_idx) begin
            st_reg <= HS_WAIT;
          end
        end
        // Answer start byte
        HS_WAIT: begin
          if (in_v && in_b == `RAS_START) begin
            cs_reg <= in_b;
            st_reg <= HS_RCMD;
          end
        end
        HS_RCMD: begin
          if (in_v) begin
            rx_cmd_reg <= in_b;
            cs_reg <= cs_reg ^ in_b;
            st_reg <= HS_RLEN;
          end
        end
        HS_RLEN: begin
          if (in_v) begin
            rx_len_reg <= in_b;
            cs_reg <= cs_reg ^ in_b;
            idx_reg <= 3'd0;
            rx_par_reg <= 16'h0000;
            st_reg <= HS_RDATA;
          end
        end
        // Status then parameters, LSB first
        HS_RDATA: begin
          if (in_v) begin
            cs_reg <= cs_reg ^ in_b;
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == 3'd0) begin
              rx_stat_reg <= in_b;
            end else if (idx_reg == 3'd1) begin
              rx_par_reg[7:0] <= in_b;
            end else begin
              rx_par_reg[15:8] <= in_b;
            end
            if ({5'd0, idx_reg} + 8'd1 >= rx_len_reg) begin
              st_reg <= HS_RCS;
            end
          end
        end
        HS_RCS: begin
          if (in_v) begin
            cserr_reg <= (in_b != cs_reg);
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            st_reg <= HS_IDLE;
          end
        end
        default: begin
          st_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.h2d_valid = h2d_valid_reg;
  assign link.h2d_data = h2d_data_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule : ras_host

// [verif/ras_link_properties.sv]
`timescale 1ns/10ps
module ras_link_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data
);
  // ---------------------------------------------------------------
  // Frame trackers for both directions
  // ---------------------------------------------------------------
  logic [3:0] h_pos; // Request byte position
  logic [3:0] d_pos; // Answer byte position
  logic [7:0] h_len, d_len, h_xor, d_xor, req_cmd, req_idx; // Captured fields
  wire h_last = h2d_valid && h_pos > 4'h2 && h_pos == h_len[3:0] + 4'h3; // Request checksum
  wire d_last = d2h_valid && d_pos > 4'h2 && d_pos == d_len[3:0] + 4'h3; // Answer checksum
  wire wide_idx = req_idx == 8'h08 || req_idx == 8'h0b; // Two-byte settings
  // Request side tracking
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {h_pos, h_len, h_xor, req_cmd, req_idx} <= '0;
    end else if (h2d_valid) begin
      h_pos <= h_last ? 4'h0 : h_pos + 4'h1;
      h_xor <= (h_pos == 4'h0) ? h2d_data : h_xor ^ h2d_data;
      if (h_pos == 4'h1) req_cmd <= h2d_data;
      if (h_pos == 4'h2) h_len <= h2d_data;
      if (h_pos == 4'h3) req_idx <= h2d_data;
    end
  end
  // Answer side tracking
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {d_pos, d_len, d_xor} <= '0;
    end else if (d2h_valid) begin
      d_pos <= d_last ? 4'h0 : d_pos + 4'h1;
      d_xor <= (d_pos == 4'h0) ? d2h_data : d_xor ^ d2h_data;
      if (d_pos == 4'h2) d_len <= d2h_data;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req_end; h2d_valid && h_last; endsequence
  sequence s_ans_open; d2h_valid && d2h_data == 8'h02; endsequence
  property p_req_start; h2d_valid && h_pos == 4'h0 |-> h2d_data == 8'h02; endproperty
  property p_req_cs; h2d_valid && h_last |-> h2d_data == h_xor; endproperty
  property p_ans_start; d2h_valid && d_pos == 4'h0 |-> d2h_data == 8'h02; endproperty
  property p_ans_cs; d2h_valid && d_last |-> d2h_data == d_xor; endproperty
  property p_ans_delay; s_req_end |-> ##3 s_ans_open; endproperty
  property p_ans_cmd; d2h_valid && d_pos == 4'h1 |-> d2h_data == (req_cmd | 8'h40); endproperty
  property p_ans_burst; d2h_valid && d_pos == 4'h0 |=> d2h_valid [*4]; endproperty
  property p_set_len;
    d2h_valid && d_pos == 4'h2 && req_cmd == 8'h09 |-> d2h_data == 8'h01;
  endproperty
  property p_get_len;
    d2h_valid && d_pos == 4'h3 && d2h_data == 8'h00 && req_cmd == 8'h0a
      |-> d_len == (wide_idx ? 8'h03 : 8'h02);
  endproperty
  property p_quiet_host; d_pos != 4'h0 |-> !h2d_valid; endproperty
  a_req_start: assert property (p_req_start) else $error("request lacks start byte");
  a_req_cs: assert property (p_req_cs) else $error("request checksum wrong");
  a_ans_start: assert property (p_ans_start) else $error("answer lacks start byte");
  a_ans_cs: assert property (p_ans_cs) else $error("answer checksum wrong");
  a_ans_delay: assert property (p_ans_delay) else $error("answer not three cycles on");
  a_ans_cmd: assert property (p_ans_cmd) else $error("answer command wrong");
  a_ans_burst: assert property (p_ans_burst) else $error("answer bytes not back to back");
  a_set_len: assert property (p_set_len) else $error("set answer length wrong");
  a_get_len: assert property (p_get_len) else $error("get answer length wrong");
  a_quiet_host: assert property (p_quiet_host) else $error("request during answer");
endmodule : ras_link_properties

// [verif/radio_address_settings_tb.sv]
`timescale 1ns/10ps
module radio_address_settings_tb;
  // ---------------------------------------------------------------
  // Clock, reset, stimulus signals
  // ---------------------------------------------------------------
  logic mclk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, pslverr, err, dest_broadcast_o;
  logic [1:0] addr_mode_i = 2'h3; // Address mode under test
  logic [7:0] dest_network_o, own_network_o;
  logic [15:0] dest_address_o, own_address_o;
  int error_cnt = 0, cmp_count = 0;
  ras_link_if link ();
  ras_device u_ras_device (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link),
    .addr_mode_i(addr_mode_i), .dest_network_o(dest_network_o),
    .dest_address_o(dest_address_o), .own_network_o(own_network_o),
    .own_address_o(own_address_o), .dest_broadcast_o(dest_broadcast_o));
  ras_host u_ras_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ras_link_properties u_ras_link_properties (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .d2h_valid(link.d2h_valid),
    .d2h_data(link.d2h_data));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    // This wait ends at the first edge where pready is seen high
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Full request frame, wait for answer, check masked status
  task automatic op(input logic [7:0] cmd, input logic [7:0] len, input logic [23:0] d,
                    input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b1, 8'h00, {16'h0, len, cmd});
    apb(1'b1, 8'h04, {8'h0, d});
    apb(1'b1, 8'h08, 32'h1);
    do begin
      apb(1'b0, 8'h0c, 32'h0);
    end while (rd[0] !== 1'b0);
    st = rd;
    chk(st & mask, exp);
    apb(1'b0, 8'h10, 32'h0);
  endtask : op
  // Change address mode and let outputs follow
  task automatic mode(input logic [1:0] m);
    addr_mode_i <= m;
    repeat (3) @(posedge mclk_i);
  endtask : mode
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  localparam logic [31:0] OKM = 32'h00ffff0f; // Status, command, all four flags
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({16'h0, dest_network_o, own_network_o}, 32'h0000ff00);
    chk({dest_address_o, own_address_o}, 32'hffff0000);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    op(8'h0a, 8'h01, 24'h08, OKM, 32'h00004a02);
    chk(rd & 32'hffff, 32'hffff);
    op(8'h09, 8'h02, 24'h0107, OKM, 32'h00004902);
    chk(dest_network_o, 32'h01);
    op(8'h0a, 8'h01, 24'h07, OKM, 32'h00004a02);
    chk(rd & 32'hff, 32'h01);
    op(8'h09, 8'h03, 24'h0907, OKM, 32'h00014902);
    chk(dest_network_o, 32'h01);
    op(8'h09, 8'h02, 24'h0108, OKM, 32'h00004902);
    chk(dest_address_o, 32'hff01);
    op(8'h0a, 8'h01, 24'h08, OKM, 32'h00004a02);
    chk(rd & 32'hffff, 32'hff01);
    op(8'h09, 8'h03, 24'h010008, OKM, 32'h00004902);
    chk(dest_address_o, 32'h0100);
    mode(2'h1);
    chk(dest_address_o, 32'h0000);
    op(8'h09, 8'h02, 24'h050a, OKM, 32'h00004902);
    op(8'h09, 8'h02, 24'h010b, OKM, 32'h00004902);
    chk({own_network_o, own_address_o}, 32'h05ff01);
    op(8'h09, 8'h03, 24'h12340b, OKM, 32'h00004902);
    chk(own_address_o, 32'h1234);
    op(8'h09, 8'h02, 24'hff0a, 32'h8, 32'h8);
    op(8'h09, 8'h03, 24'hffff0b, 32'h8, 32'h8);
    chk({own_network_o, own_address_o}, 32'h051234);
    op(8'h2a, 8'h01, 24'h33, OKM, 32'h00006a02);
    chk(dest_network_o, 32'h33);
    op(8'h0a, 8'h01, 24'h07, OKM, 32'h00004a02);
    chk(rd & 32'hff, 32'h01);
    op(8'h09, 8'h02, 24'hff07, OKM, 32'h00004902);
    op(8'h09, 8'h03, 24'hffff08, OKM, 32'h00004902);
    mode(2'h3);
    chk(dest_broadcast_o, 32'h1);
    op(8'h2b, 8'h01, 24'h05, OKM, 32'h00006b02);
    chk({dest_broadcast_o, dest_address_o}, 32'h0ff05);
    mode(2'h1);
    chk(dest_broadcast_o, 32'h0);
    op(8'h2b, 8'h02, 24'h12ff, OKM, 32'h00006b02);
    chk(dest_broadcast_o, 32'h1);
    // Mode 2: either byte at broadcast is enough
    mode(2'h2);
    chk({dest_broadcast_o, dest_address_o}, 32'h100ff);
    op(8'h2a, 8'h01, 24'h01, OKM, 32'h00006a02);
    op(8'h2b, 8'h01, 24'h05, OKM, 32'h00006b02);
    chk({dest_broadcast_o, dest_address_o}, 32'h00005);
    // Mode 0: no addressing, always broadcast
    mode(2'h0);
    chk({dest_broadcast_o, dest_address_o}, 32'h10005);
    summarize();
  end
  // Hang guard
  initial begin
    #(100ns * 60000);
    error_cnt++;
    summarize();
  end
endmodule : radio_address_settings_tb
